//--- cte_trigger.sv
// Purpose: majority coincidence trigger, edge time capture, rate counters, display
// Assumes: discriminator inputs asynchronous, APB master in the pclk domain
// Notes:   times are sampling ticks relative to the trigger, two's complement
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
// Function
// [RULE1] fold level selectable from one to four
// [RULE2] any channels meeting fold count trigger
// [RULE3] first rise opens window of adjustable width
// [RULE4] fold reached inside window latches event
// [RULE5] report spans only the overlap interval; here it spans from the window opening to the overlap end
// [RULE6] edges for all channels, empty if inactive
// [RULE7] discriminator state sampled at fixed interval
// [RULE8] lead and trail times relative to trigger
// [RULE9] high input means channel above threshold
// [RULE10] four singles counters plus trigger counter
// [RULE11] controller clears counters, totals accumulate
// [RULE12] four digit display counts coincidences
// [RULE13] one pulse on trigger output per trigger
// [RULE14] only first record carries start flag
// [RULE15] stop and start commands gate counting
// [RULE16] expired window discards event and re-arms
// [RULE17] inputs synchronised before any use
module cte_trigger #(
    parameter int NCH = cte_pkg::NCH,
    parameter int TW  = cte_pkg::TW
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic [NCH-1:0] disc_in,
    output logic                trigger_pulse_out,
    output logic      [15:0]    disp_bcd,
    output logic                irq
);
    localparam int CW = cte_pkg::CNT_W;
    localparam int WW = cte_pkg::WIN_W;
    localparam int AW = $clog2(NCH);

    // elaboration check: the record word layout is fixed by the package
    if (NCH != cte_pkg::NCH || TW != cte_pkg::TW) begin : g_bad_param
        $error("cte_trigger: NCH and TW must match the package layout");
    end

    // number of channels high at once
    function automatic logic [2:0] pop_count(input logic [NCH-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NCH; i++) begin
            n = n + 3'(v[i]);
        end
        return n;
    endfunction

    // one bcd digit step with carry
    function automatic logic [4:0] bcd_step(input logic [3:0] d, input logic cin);
        logic [4:0] r;
        r = 5'h0;
        if (cin) begin
            r = (d == 4'h9) ? 5'h10 : {1'b0, d + 4'h1};
        end else begin
            r = {1'b0, d};
        end
        return r;
    endfunction

    cte_pkg::cte_state_e state_q;
    logic [NCH-1:0]   sync1_q, sync2_q, prev_q;
    logic [NCH-1:0]   rise, fall;
    logic [2:0]       active_n;
    logic [TW-1:0]    ts_q, trig_ts_q, end_ts_q;
    logic [WW-1:0]    win_cnt_q, win_q;
    logic [2:0]       fold_q;
    logic             run_q;
    logic [NCH-1:0]   seen_q, gone_q;
    logic [TW-1:0]    lead_q [NCH];
    logic [TW-1:0]    trail_q [NCH];
    logic [AW-1:0]    wr_idx_q, rd_ptr_q;
    logic             pending_q;
    logic [CW-1:0]    cnt_q [NCH+1];
    logic [cte_pkg::ST_W-1:0] stat_q, mask_q, stat_set;
    logic             fire, drop, wr_acc, rd_acc, clr_cmd, rec_rd, mem_we;
    cte_pkg::cte_rec_s wr_rec, rd_rec;

    // two stage synchroniser; only the second stage feeds logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= disc_in;        // see [RULE17]
            sync2_q <= sync1_q;        // see [RULE7]
            prev_q  <= sync2_q;
        end
    end

    // high level means above threshold
    assign rise     = sync2_q & ~prev_q;   // see [RULE9]
    assign fall     = ~sync2_q & prev_q;
    assign active_n = pop_count(sync2_q);  // see [RULE2]

    // free running tick counter; wraps, so events must stay short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_q <= '0;
        end else begin
            ts_q <= ts_q + TW'(1);
        end
    end

    assign fire = (state_q == cte_pkg::ST_OPEN) && (active_n >= fold_q); // see [RULE4]
    assign drop = (state_q == cte_pkg::ST_OPEN) && !fire && (win_cnt_q <= WW'(1));

    // event sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= cte_pkg::ST_IDLE;
            win_cnt_q <= '0;
            trig_ts_q <= '0;
            end_ts_q  <= '0;
            wr_idx_q  <= '0;
        end else begin
            unique case (state_q)
                cte_pkg::ST_IDLE: begin
                    if (|rise) begin
                        state_q   <= cte_pkg::ST_OPEN;   // see [RULE3]
                        win_cnt_q <= win_q;
                    end
                end
                cte_pkg::ST_OPEN: begin
                    if (fire) begin
                        state_q   <= cte_pkg::ST_OVERLAP;
                        trig_ts_q <= ts_q;               // see [RULE8]
                    end else if (drop) begin
                        state_q   <= cte_pkg::ST_IDLE;   // see [RULE16]
                    end else begin
                        win_cnt_q <= win_cnt_q - WW'(1);
                    end
                end
                cte_pkg::ST_OVERLAP: begin
                    if (active_n < fold_q) begin
                        state_q  <= cte_pkg::ST_STORE;   // see [RULE5]
                        end_ts_q <= ts_q;
                        wr_idx_q <= '0;
                    end
                end
                cte_pkg::ST_STORE: begin
                    wr_idx_q <= wr_idx_q + AW'(1);
                    if (wr_idx_q == AW'(NCH - 1)) begin
                        state_q <= cte_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // per channel edge capture during window and overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= '0;
            gone_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                lead_q[i]  <= '0;
                trail_q[i] <= '0;
            end
        end else if (state_q == cte_pkg::ST_IDLE) begin
            seen_q <= rise;
            gone_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                lead_q[i] <= ts_q;
            end
        end else if (state_q != cte_pkg::ST_STORE) begin
            for (int i = 0; i < NCH; i++) begin
                if (rise[i] && !seen_q[i]) begin
                    seen_q[i] <= 1'b1;       // see [RULE6]
                    lead_q[i] <= ts_q;
                end
                if (fall[i] && seen_q[i] && !gone_q[i]) begin
                    gone_q[i]  <= 1'b1;
                    trail_q[i] <= ts_q;
                end
            end
        end
    end

    // record word: times relative to trigger, still-high pulses end at overlap end
    always_comb begin
        wr_rec       = '0;
        wr_rec.empty = !seen_q[wr_idx_q];                             // see [RULE6]
        wr_rec.lead  = lead_q[wr_idx_q] - trig_ts_q;                  // see [RULE8]
        wr_rec.trail = (gone_q[wr_idx_q] ? trail_q[wr_idx_q] : end_ts_q) - trig_ts_q;
    end
    assign mem_we = (state_q == cte_pkg::ST_STORE);

    cte_rec_mem #(
        .DEPTH (NCH)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (mem_we),
        .wr_addr (wr_idx_q),
        .wr_data (wr_rec),
        .rd_addr (rd_ptr_q),
        .rd_data (rd_rec)
    );

    // apb decode; slave never waits
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign clr_cmd = wr_acc && (paddr == cte_pkg::OFS_CTRL) && pwdata[cte_pkg::CTRL_CLR_BIT];
    assign rec_rd  = rd_acc && (paddr == cte_pkg::OFS_REC) && pending_q;
    assign pready  = 1'b1;

    // software controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fold_q <= cte_pkg::RST_FOLD;
            run_q  <= cte_pkg::RST_RUN;
            win_q  <= cte_pkg::RST_WIN;
            mask_q <= '0;
        end else if (wr_acc) begin
            if (paddr == cte_pkg::OFS_CTRL) begin
                // zero is lifted to one and anything above the channel count clamps
                if (pwdata[2:0] == 3'h0) begin
                    fold_q <= 3'h1;
                end else if (pwdata[2:0] > 3'(NCH)) begin
                    fold_q <= 3'(NCH);
                end else begin
                    fold_q <= pwdata[2:0];                           // see [RULE1]
                end
                run_q <= pwdata[cte_pkg::CTRL_RUN_BIT];              // see [RULE15]
            end
            if (paddr == cte_pkg::OFS_WIN && pwdata[WW-1:0] != '0) begin
                win_q <= pwdata[WW-1:0];                             // see [RULE3]
            end
            if (paddr == cte_pkg::OFS_MASK) begin
                mask_q <= pwdata[cte_pkg::ST_W-1:0];
            end
        end
    end

    // sticky status, a new event beats a same-cycle clear
    assign stat_set = {drop, fire};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else if (wr_acc && paddr == cte_pkg::OFS_STAT) begin
            stat_q <= (stat_q & ~pwdata[cte_pkg::ST_W-1:0]) | stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end
    assign irq = |(stat_q & mask_q);

    // record readout pointer; a new event restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q <= 1'b0;
            rd_ptr_q  <= '0;
        end else if (mem_we && wr_idx_q == AW'(NCH - 1)) begin
            pending_q <= 1'b1;
            rd_ptr_q  <= '0;
        end else if (rec_rd) begin
            rd_ptr_q <= rd_ptr_q + AW'(1);
            if (rd_ptr_q == AW'(NCH - 1)) begin
                pending_q <= 1'b0;
            end
        end
    end

    // rate counters: singles per channel, triggers in the last slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i <= NCH; i++) begin
                cnt_q[i] <= '0;
            end
        end else if (clr_cmd) begin
            for (int i = 0; i <= NCH; i++) begin
                cnt_q[i] <= '0;                                      // see [RULE11]
            end
        end else if (run_q) begin
            for (int i = 0; i < NCH; i++) begin
                cnt_q[i] <= cnt_q[i] + CW'(rise[i]);                 // see [RULE10]
            end
            cnt_q[NCH] <= cnt_q[NCH] + CW'(fire);                    // see [RULE15]
        end
    end

    // coincidence display counts from reset, independent of run; wraps after 9999
    logic [4:0] d0, d1, d2, d3;
    assign d0 = bcd_step(disp_bcd[3:0], fire);
    assign d1 = bcd_step(disp_bcd[7:4], d0[4]);
    assign d2 = bcd_step(disp_bcd[11:8], d1[4]);
    assign d3 = bcd_step(disp_bcd[15:12], d2[4]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_bcd <= '0;
        end else begin
            disp_bcd <= {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};       // see [RULE12]
        end
    end

    // trigger output, one cycle per trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_pulse_out <= 1'b0;
        end else begin
            trigger_pulse_out <= fire;                               // see [RULE13]
        end
    end

    // read mux from registered state
    always_comb begin
        prdata  = '0;
        pslverr = 1'b0;
        if (paddr >= cte_pkg::OFS_CNT0 && paddr <= cte_pkg::OFS_CNT0 + 8'(4 * NCH)
            && paddr[1:0] == 2'h0) begin
            prdata = cnt_q[3'(paddr[4:2])];
        end else begin
            unique case (paddr)
                cte_pkg::OFS_CTRL: prdata = {27'h0, 1'b0, run_q, fold_q};
                cte_pkg::OFS_WIN:  prdata = {24'h0, win_q};
                cte_pkg::OFS_STAT: prdata = {30'h0, stat_q};
                cte_pkg::OFS_MASK: prdata = {30'h0, mask_q};
                cte_pkg::OFS_EVT:  prdata = {28'h0, state_q, 1'b0, pending_q};
                cte_pkg::OFS_DISP: prdata = {16'h0, disp_bcd};
                cte_pkg::OFS_REC: begin
                    prdata[cte_pkg::REC_START_BIT] = pending_q && rd_ptr_q == '0; // see [RULE14]
                    prdata[cte_pkg::REC_EMPTY_BIT] = rd_rec.empty;
                    prdata[cte_pkg::REC_CH_LSB +: 2] = 2'(rd_ptr_q);
                    prdata[cte_pkg::REC_LEAD_LSB +: TW] = rd_rec.lead;
                    prdata[TW-1:0] = rd_rec.trail;
                end
                default: pslverr = psel && penable;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // helper: cycles spent with the window open
    logic [WW:0] open_len_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_len_q <= '0;
        end else begin
            open_len_q <= (state_q == cte_pkg::ST_OPEN) ? open_len_q + (WW+1)'(1) : '0;
        end
    end

    sequence s_fire_cycle;
        state_q == cte_pkg::ST_OPEN && active_n >= fold_q;
    endsequence
    sequence s_pulse_once;
        trigger_pulse_out ##1 !trigger_pulse_out;
    endsequence

    a_sync_two_stages: assert property (rise[0] |-> $past(disc_in[0], 2) && !$past(disc_in[0], 3))   // see [RULE17]
        else $error("input edge not delayed by two stages");
    a_fold_majority: assert property (s_fire_cycle |-> ##1 state_q == cte_pkg::ST_OVERLAP)   // see [RULE2]
        else $error("fold reached without trigger");
    a_trig_pulse_one: assert property (s_fire_cycle |=> s_pulse_once)   // see [RULE13]
        else $error("trigger output not a single pulse");
    a_trig_cause: assert property ($rose(trigger_pulse_out) |-> $past(active_n) >= $past(fold_q))   // see [RULE4]
        else $error("trigger without enough channels");
    a_window_width: assert property (open_len_q <= (WW+1)'(win_q))   // see [RULE3]
        else $error("window open longer than set width");
    a_drop_rearm: assert property (drop |=> state_q == cte_pkg::ST_IDLE && !trigger_pulse_out)   // see [RULE16]
        else $error("expired window did not discard");
    a_overlap_end: assert property (state_q == cte_pkg::ST_OVERLAP && active_n < fold_q
        |=> state_q == cte_pkg::ST_STORE ##(NCH) state_q == cte_pkg::ST_IDLE)   // see [RULE5]
        else $error("overlap end not followed by store");
    a_cnt_clear: assert property (clr_cmd |=> cnt_q[NCH] == '0 && cnt_q[0] == '0)   // see [RULE11]
        else $error("counters not cleared");
    a_cnt_stopped: assert property (!run_q && !clr_cmd |=> $stable(cnt_q[NCH]) && $stable(cnt_q[0]))   // see [RULE15]
        else $error("counter moved while stopped");
    a_trig_count: assert property (run_q && fire && !clr_cmd |=> cnt_q[NCH] == $past(cnt_q[NCH]) + CW'(1))   // see [RULE10]
        else $error("trigger counter missed an event");
    a_disp_advance: assert property (fire |=> disp_bcd != $past(disp_bcd))   // see [RULE12]
        else $error("display did not advance");
    a_irq_level: assert property (irq == |(stat_q & mask_q) && (stat_q[0] || !$past(fire)))
        else $error("interrupt level or sticky trigger bit wrong");
endmodule // cte_trigger

//--- cte_pkg.sv
// Purpose: shared constants and types of the coincidence trigger and edge timer
// Assumes: 50 MHz pclk, APB register access, four discriminator channels
// Notes:   edge times count sampling ticks; here one tick is one pclk cycle
package cte_pkg;
    // geometry
    localparam int NCH = 4;
    localparam int TW  = 14;
    localparam int CNT_W = 32;
    localparam int WIN_W = 8;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int WINDOW_NS     = 240;
    localparam int SAMPLE_PS     = 750;
    localparam int WINDOW_CYC    = WINDOW_NS / CLK_PERIOD_NS; // longest time rounds down

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WIN  = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_EVT  = 8'h10;
    localparam logic [7:0] OFS_REC  = 8'h14;
    localparam logic [7:0] OFS_DISP = 8'h18;
    localparam logic [7:0] OFS_CNT0 = 8'h20;

    // control fields
    localparam int CTRL_FOLD_LSB = 0;
    localparam int CTRL_FOLD_W   = 3;
    localparam int CTRL_RUN_BIT  = 3;
    localparam int CTRL_CLR_BIT  = 4;
    localparam logic [2:0]       RST_FOLD = 3'h2;
    localparam logic             RST_RUN  = 1'b1;
    localparam logic [WIN_W-1:0] RST_WIN  = WIN_W'(WINDOW_CYC);

    // status and mask bits
    localparam int ST_TRIG = 0;
    localparam int ST_DROP = 1;
    localparam int ST_W    = 2;

    // record read word layout
    localparam int REC_START_BIT = 31;
    localparam int REC_EMPTY_BIT = 30;
    localparam int REC_CH_LSB    = 28;
    localparam int REC_LEAD_LSB  = 14;

    typedef struct packed {
        logic          empty;
        logic [TW-1:0] lead;
        logic [TW-1:0] trail;
    } cte_rec_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OPEN,
        ST_OVERLAP,
        ST_STORE
    } cte_state_e;
endpackage

//--- cte_rec_mem.sv
// Purpose: small record store for one event, one word per channel
// Assumes: single clock, one write port, one read port
// Notes:   read data come from a register, one cycle after the address
`timescale 1ns/1ps
module cte_rec_mem #(
    parameter int DEPTH = 4,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  cte_pkg::cte_rec_s     wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output cte_pkg::cte_rec_s     rd_data
);
    cte_pkg::cte_rec_s mem_q [DEPTH];

    // elaboration check: a single word cannot hold one record per channel
    if (DEPTH < 2) begin : g_bad_depth
        $error("cte_rec_mem: DEPTH must be at least 2");
    end

    // storage array, no reset needed since reads are gated by pending flag
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule // cte_rec_mem

//--- cte_mcu_model.sv
// Purpose: board controller model, APB master that drives the trigger block
// Assumes: one pclk domain; the slave may add wait states
// Notes:   signals change by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
module cte_mcu_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // one transfer; the answer is taken at the rising edge that sees pready high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        logic rdy;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            rdy = pready;
            q   = prdata;
            err = pslverr;
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d; // stale data must not look valid once released
    endtask

    // control command: fold level, counting on or off, counter clear
    task automatic cmd_ctrl(input logic [2:0] fold, input logic run, input logic clr);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, cte_pkg::OFS_CTRL, {27'h0, clr, run, fold}, q, e);
    endtask
endmodule // cte_mcu_model

//--- coincidence_trigger_edge_timer_bench.sv
// Purpose: self-checking bench of the coincidence trigger and edge timer
// Assumes: 50 MHz pclk; one tick of edge time is one pclk cycle
// Notes:   expected values come from the bench's own event bookkeeping
`timescale 1ns/1ps
module coincidence_trigger_edge_timer_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  disc_in;
    logic        trigger_pulse_out;
    logic [15:0] disp_bcd;
    logic        irq;
    int          num_errors;
    int          samples_checked;
    int          pulses;
    int          exp_trig;
    logic [31:0] q;
    logic        err;
    logic [31:0] rec [4];
    logic [3:0]  hi_pat [1:4] = '{4'h4, 4'hA, 4'hD, 4'hF};
    logic [3:0]  lo_pat [1:4] = '{4'h0, 4'h1, 4'h6, 4'hB};

    cte_trigger dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .disc_in(disc_in),
        .trigger_pulse_out(trigger_pulse_out), .disp_bcd(disp_bcd), .irq(irq));

    cte_mcu_model mcu_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // clock and trigger pulse tally
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (trigger_pulse_out === 1'b1) pulses <= pulses + 1;

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        mcu_u.xfer(1'b0, a, 32'h0, q, err);
        chk(nm, e, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mcu_u.xfer(1'b1, a, d, q, err);
    endtask

    // pattern held n cycles, then quiet long enough for a window of up to 12 cycles to close
    task automatic burst(input logic [3:0] p, input int n);
        @(posedge pclk);
        disc_in <= p;
        tick(n);
        disc_in <= 4'h0;
        tick(24);
    endtask

    function automatic logic [31:0] to_bcd(input int v);
        return {16'h0, 4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        complete_run();
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; disc_in = 4'h0;
        num_errors = 0; samples_checked = 0; pulses = 0; exp_trig = 0;
        tick(4);
        presetn <= 1'b1;
        rd(cte_pkg::OFS_CTRL, 32'h0000000A, "ctrl default");
        rd(cte_pkg::OFS_WIN, 32'h0000000C, "window default");
        rd(cte_pkg::OFS_MASK, 32'h0, "mask default");
        mcu_u.xfer(1'b0, 8'h1C, 32'h0, q, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        // two-fold event: ch1 rises three ticks after ch0, high for three ticks
        @(posedge pclk) disc_in <= 4'h1;
        tick(3); disc_in <= 4'h3;
        tick(3); disc_in <= 4'h1;
        tick(4); disc_in <= 4'h0;
        tick(24);
        exp_trig++;
        chk("pulse count", exp_trig, pulses);
        rd(cte_pkg::OFS_EVT, 32'h1, "pending");
        for (int i = 0; i < 4; i++) begin
            mcu_u.xfer(1'b0, cte_pkg::OFS_REC, 32'h0, rec[i], err);
            chk("rec start", 32'(i == 0), rec[i][31]);
            chk("rec empty", 32'(i > 1), rec[i][30]);
            chk("rec chan", i, rec[i][29:28]);
        end
        chk("lead gap", 14'h3, 14'(rec[1][27:14] - rec[0][27:14]));
        chk("width", 14'h3, 14'(rec[1][13:0] - rec[1][27:14]));
        rd(cte_pkg::OFS_EVT, 32'h0, "drained");
        for (int i = 0; i < 5; i++) begin
            rd(8'(cte_pkg::OFS_CNT0 + 4 * i), 32'(i < 2 || i == 4), "counter");
        end
        // interrupt raised by mask, cleared by writing one
        rd(cte_pkg::OFS_STAT, 32'h1, "status trig");
        @(negedge pclk) chk("irq masked", 32'h0, irq);
        wr(cte_pkg::OFS_MASK, 32'h1);
        @(negedge pclk) chk("irq set", 32'h1, irq);
        wr(cte_pkg::OFS_STAT, 32'h1);
        @(negedge pclk) chk("irq clear", 32'h0, irq);
        // short window, lone channel: expires and re-arms
        wr(cte_pkg::OFS_WIN, 32'h4);
        wr(cte_pkg::OFS_WIN, 32'h0);
        rd(cte_pkg::OFS_WIN, 32'h4, "window kept");
        burst(4'h4, 2);
        rd(cte_pkg::OFS_STAT, 32'h2, "status drop");
        rd(cte_pkg::OFS_EVT, 32'h0, "idle no data");
        chk("no pulse", exp_trig, pulses);
        wr(cte_pkg::OFS_MASK, 32'h2);
        @(negedge pclk) chk("irq drop", 32'h1, irq);
        wr(cte_pkg::OFS_STAT, 32'h2);
        wr(cte_pkg::OFS_WIN, 32'hC);
        // every fold level: a full set fires; from fold two up, one channel short stays quiet
        for (int f = 1; f <= 4; f++) begin
            mcu_u.cmd_ctrl(3'(f), 1'b1, 1'b0);
            if (f > 1) burst(lo_pat[f], 6);
            chk("short set", exp_trig, pulses);
            burst(hi_pat[f], 6);
            exp_trig++;
            chk("full set", exp_trig, pulses);
        end
        chk("display", to_bcd(exp_trig), {16'h0, disp_bcd});
        rd(8'(cte_pkg::OFS_CNT0 + 16), 32'(exp_trig), "trig counter");
        // fold codes outside one to four are clamped into range
        mcu_u.cmd_ctrl(3'h0, 1'b1, 1'b0);
        rd(cte_pkg::OFS_CTRL, 32'h00000009, "fold low clamp");
        mcu_u.cmd_ctrl(3'h7, 1'b1, 1'b0);
        rd(cte_pkg::OFS_CTRL, 32'h0000000C, "fold high clamp");
        // clear, stop and start counting
        mcu_u.cmd_ctrl(3'h2, 1'b1, 1'b1);
        for (int i = 0; i < 5; i++) begin
            rd(8'(cte_pkg::OFS_CNT0 + 4 * i), 32'h0, "cleared");
        end
        mcu_u.cmd_ctrl(3'h2, 1'b0, 1'b0);
        burst(4'h8, 2);
        rd(8'(cte_pkg::OFS_CNT0 + 12), 32'h0, "stopped");
        mcu_u.cmd_ctrl(3'h2, 1'b1, 1'b0);
        burst(4'h8, 2);
        rd(8'(cte_pkg::OFS_CNT0 + 12), 32'h1, "running");
        chk("display kept", to_bcd(exp_trig), {16'h0, disp_bcd});
        complete_run();
    end
endmodule // coincidence_trigger_edge_timer_bench
